// *** logic/retimer_ctl_pkg.sv ***
// shared constants and carriers for the per-channel retimer override control
// assumes a decoded per-channel register port ahead of it (serial bus slave lives elsewhere)
package retimer_ctl_pkg;

  localparam int NUM_CH = 4;
  localparam int CH_W   = 2;

  // register offsets
  localparam logic [7:0] OFS_BOOST_APPLIED   = 8'h03;
  localparam logic [7:0] OFS_TUNE_CODE_ONE   = 8'h08;
  localparam logic [7:0] OFS_OVERRIDE_EN     = 8'h09;
  localparam logic [7:0] OFS_TUNE_CODE_TWO   = 8'h0B;
  localparam logic [7:0] OFS_STAGE_CONTROL   = 8'h13;
  localparam logic [7:0] OFS_SIG_DETECT_CTL  = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_SELECT   = 8'h1E;
  localparam logic [7:0] OFS_RATE_SUBRATE    = 8'h2F;
  localparam logic [7:0] OFS_ADAPT_MODE      = 8'h31;
  localparam logic [7:0] OFS_SEARCH_CONTROL  = 8'h36;
  localparam logic [7:0] OFS_LOW_RATE_BOOST  = 8'h3A;

  // values after reset
  localparam logic [7:0] RST_ZERO            = 8'h00;
  localparam logic [7:0] RST_OUTPUT_SELECT   = 8'hE0;

  // field positions
  localparam int ADAPT_MODE_HI  = 6;
  localparam int ADAPT_MODE_LO  = 5;
  localparam int LIMIT_BIT      = 2;
  localparam int SEARCH_HI      = 5;
  localparam int SEARCH_LO      = 4;
  localparam int RATE_HI        = 7;
  localparam int RATE_LO        = 6;
  localparam int SUBRATE_HI     = 5;
  localparam int SUBRATE_LO     = 4;
  localparam int CODE_HI        = 4;
  localparam int CODE_LO        = 0;
  localparam int OVR_TUNE_BIT   = 7;
  localparam int OVR_MUX_BIT    = 5;
  localparam int OVR_QCLK_BIT   = 4;
  localparam int QCLK_EN_BIT    = 0;
  localparam int SD_FORCE_ON    = 7;
  localparam int SD_FORCE_OFF   = 6;
  localparam int OUTSEL_HI      = 7;
  localparam int OUTSEL_LO      = 5;

  localparam logic [1:0] SEARCH_INITIAL = 2'h3;
  localparam logic [1:0] ADAPT_FIXED    = 2'h0;

  // output source codes
  localparam logic [2:0] SRC_RAW      = 3'h0;
  localparam logic [2:0] SRC_RETIMED  = 3'h1;
  localparam logic [2:0] SRC_INPHASE  = 3'h2;
  localparam logic [2:0] SRC_QUAD     = 3'h3;
  localparam logic [2:0] SRC_PATTERN  = 3'h4;
  localparam logic [2:0] SRC_INTCLK   = 3'h5;
  localparam logic [2:0] SRC_INVALID  = 3'h6;
  localparam logic [2:0] SRC_MUTE     = 3'h7;

  typedef enum logic [1:0] {TUNE_IDLE, TUNE_FIRST, TUNE_SECOND} tune_state_e;

  typedef struct packed {
    logic       sig_present;
    logic       cdr_locked;
    logic       adapt_update;
    logic [7:0] adapt_boost;
    logic       rate_fallback;
    logic       lock_attempt_fail;
  } chan_status_s;

  typedef struct packed {
    logic       channel_enable;
    logic [2:0] out_select;
    logic       limiting;
    logic [7:0] boost;
    logic       tune_override;
    logic [4:0] tune_code;
    logic       divide_by_8;
    logic       search_request;
    logic [1:0] rate;
    logic [1:0] subrate;
    logic       sync_to_input;
  } chan_ctrl_s;

endpackage

// *** logic/tune_alternator.sv ***
// alternating coarse tuning attempt sequencer for one channel
// assumes lock_fail is a one-cycle pulse per failed lock attempt
`timescale 1ns/1ps
module tune_alternator (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       override_en,
  input  wire logic [4:0] code_one,
  input  wire logic [4:0] code_two,
  input  wire logic       locked,
  input  wire logic       lock_fail,
  output logic            active_q,
  output logic [4:0]      code_q,
  output logic            div8_q
);
  retimer_ctl_pkg::tune_state_e state_q;
  retimer_ctl_pkg::tune_state_e state_d;
  logic [4:0]                   code_d;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      retimer_ctl_pkg::TUNE_IDLE:   if (override_en) state_d = retimer_ctl_pkg::TUNE_FIRST;
      retimer_ctl_pkg::TUNE_FIRST:  if (lock_fail && !locked) state_d = retimer_ctl_pkg::TUNE_SECOND;
      retimer_ctl_pkg::TUNE_SECOND: if (lock_fail && !locked) state_d = retimer_ctl_pkg::TUNE_FIRST;
      default:                      state_d = retimer_ctl_pkg::TUNE_IDLE;
    endcase
    // clearing the override ends the alternation at once
    if (!override_en)
      state_d = retimer_ctl_pkg::TUNE_IDLE;
    code_d = (state_d == retimer_ctl_pkg::TUNE_SECOND) ? code_two : code_one;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= retimer_ctl_pkg::TUNE_IDLE;
      active_q <= 1'b0;
      code_q   <= 5'h00;
      div8_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      active_q <= (state_d != retimer_ctl_pkg::TUNE_IDLE);
      code_q   <= code_d;
      div8_q   <= (state_d == retimer_ctl_pkg::TUNE_FIRST);
    end
  end
endmodule

// *** logic/retimer_override_ctl.sv ***
// Overview of operation
// - boost register reads the boost in force
// - lower-rate step loads low-rate boost into boost
// - adapt mode zero falls back using low-rate boost
// - adapt mode zero retries without touching boost
// - stage control bit 2 sets limiting mode
// - search field 2'b11 starts initial coarse search unless tuning override is active
// - rate and subrate bound the search range
// - tuning codes apply only with override enable
// - alternate code one div 8, code two div 1
// - selector codes: mute, invalid, clocks, pattern, data
// - without override selector acts only when unlocked
// - mux override drives selector even when locked
// - no signal detected powers down and mutes
// - bit7 set, bit6 clear forces detect on
// - both detect bits clear gives automatic detect
// - locked channel with signal detected keeps clocks synchronous to input
// - internal clock selectable when mux overridden and signal detected
// per-channel register store and output steering for a quad retimer
// assumes a decoded register port with channel select; status inputs synchronous to ref_clk
`timescale 1ns/1ps
module retimer_override_ctl #(
  parameter int NUM_CH = retimer_ctl_pkg::NUM_CH
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         wr_en,
  input  wire logic [1:0]                   wr_chan,
  input  wire logic [7:0]                   wr_addr,
  input  wire logic [7:0]                   wr_data,
  input  wire logic                         rd_en,
  input  wire logic [1:0]                   rd_chan,
  input  wire logic [7:0]                   rd_addr,
  input  wire retimer_ctl_pkg::chan_status_s status [NUM_CH],
  output logic [7:0]                        rd_data_q,
  output logic                              rd_valid_q,
  output retimer_ctl_pkg::chan_ctrl_s       ctrl_q [NUM_CH]
);
  logic [7:0] rd_data_d;
  logic [7:0] rd_word [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_chan
    logic [7:0] boost_q;
    logic [7:0] boost_d;
    logic [7:0] code1_q;
    logic [7:0] code1_d;
    logic [7:0] ovr_q;
    logic [7:0] ovr_d;
    logic [7:0] code2_q;
    logic [7:0] code2_d;
    logic [7:0] stage_q;
    logic [7:0] stage_d;
    logic [7:0] sd_q;
    logic [7:0] sd_d;
    logic [7:0] osel_q;
    logic [7:0] osel_d;
    logic [7:0] rate_q;
    logic [7:0] rate_d;
    logic [7:0] adapt_q;
    logic [7:0] adapt_d;
    logic [7:0] search_q;
    logic [7:0] search_d;
    logic [7:0] lowb_q;
    logic [7:0] lowb_d;
    logic       we;
    logic       fixed_mode;
    logic       detected;
    logic       tune_act;
    logic [4:0] tune_code;
    logic       tune_div8;
    logic [2:0] sel;
    retimer_ctl_pkg::chan_ctrl_s ctrl_d;

    // each channel decodes only writes aimed at itself
    assign we = wr_en && (wr_chan == 2'(c));
    assign fixed_mode = (adapt_q[retimer_ctl_pkg::ADAPT_MODE_HI:retimer_ctl_pkg::ADAPT_MODE_LO]
                         == retimer_ctl_pkg::ADAPT_FIXED);

    always_comb
    begin
      code1_d  = (we && wr_addr == retimer_ctl_pkg::OFS_TUNE_CODE_ONE)  ? wr_data : code1_q;
      ovr_d    = (we && wr_addr == retimer_ctl_pkg::OFS_OVERRIDE_EN)    ? wr_data : ovr_q;
      code2_d  = (we && wr_addr == retimer_ctl_pkg::OFS_TUNE_CODE_TWO)  ? wr_data : code2_q;
      stage_d  = (we && wr_addr == retimer_ctl_pkg::OFS_STAGE_CONTROL)  ? wr_data : stage_q;
      sd_d     = (we && wr_addr == retimer_ctl_pkg::OFS_SIG_DETECT_CTL) ? wr_data : sd_q;
      osel_d   = (we && wr_addr == retimer_ctl_pkg::OFS_OUTPUT_SELECT)  ? wr_data : osel_q;
      rate_d   = (we && wr_addr == retimer_ctl_pkg::OFS_RATE_SUBRATE)   ? wr_data : rate_q;
      adapt_d  = (we && wr_addr == retimer_ctl_pkg::OFS_ADAPT_MODE)     ? wr_data : adapt_q;
      search_d = (we && wr_addr == retimer_ctl_pkg::OFS_SEARCH_CONTROL) ? wr_data : search_q;
      lowb_d   = (we && wr_addr == retimer_ctl_pkg::OFS_LOW_RATE_BOOST) ? wr_data : lowb_q;
      boost_d  = (we && wr_addr == retimer_ctl_pkg::OFS_BOOST_APPLIED)  ? wr_data : boost_q;
      // hardware updates win over a software write in the same cycle
      if (status[c].adapt_update && !fixed_mode)
        boost_d = status[c].adapt_boost;
      if (status[c].rate_fallback)
        boost_d = lowb_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        boost_q  <= retimer_ctl_pkg::RST_ZERO;
        code1_q  <= retimer_ctl_pkg::RST_ZERO;
        ovr_q    <= retimer_ctl_pkg::RST_ZERO;
        code2_q  <= retimer_ctl_pkg::RST_ZERO;
        stage_q  <= retimer_ctl_pkg::RST_ZERO;
        sd_q     <= retimer_ctl_pkg::RST_ZERO;
        osel_q   <= retimer_ctl_pkg::RST_OUTPUT_SELECT;
        rate_q   <= retimer_ctl_pkg::RST_ZERO;
        adapt_q  <= retimer_ctl_pkg::RST_ZERO;
        search_q <= retimer_ctl_pkg::RST_ZERO;
        lowb_q   <= retimer_ctl_pkg::RST_ZERO;
      end
      else
      begin
        boost_q  <= boost_d;
        code1_q  <= code1_d;
        ovr_q    <= ovr_d;
        code2_q  <= code2_d;
        stage_q  <= stage_d;
        sd_q     <= sd_d;
        osel_q   <= osel_d;
        rate_q   <= rate_d;
        adapt_q  <= adapt_d;
        search_q <= search_d;
        lowb_q   <= lowb_d;
      end
    end

    tune_alternator u_tune (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .override_en (ovr_q[retimer_ctl_pkg::OVR_TUNE_BIT]),
      .code_one    (code1_q[retimer_ctl_pkg::CODE_HI:retimer_ctl_pkg::CODE_LO]),
      .code_two    (code2_q[retimer_ctl_pkg::CODE_HI:retimer_ctl_pkg::CODE_LO]),
      .locked      (status[c].cdr_locked),
      .lock_fail   (status[c].lock_attempt_fail),
      .active_q    (tune_act),
      .code_q      (tune_code),
      .div8_q      (tune_div8)
    );

    always_comb
    begin
      // force-off bit alone or with force-on keeps the channel down
      if (sd_q[retimer_ctl_pkg::SD_FORCE_ON] && !sd_q[retimer_ctl_pkg::SD_FORCE_OFF])
        detected = 1'b1;
      else if (!sd_q[retimer_ctl_pkg::SD_FORCE_ON] && !sd_q[retimer_ctl_pkg::SD_FORCE_OFF])
        detected = status[c].sig_present;
      else
        detected = 1'b0;
      sel = osel_q[retimer_ctl_pkg::OUTSEL_HI:retimer_ctl_pkg::OUTSEL_LO];
      // invalid code and an unenabled quadrature clock fall back to mute
      if (sel == retimer_ctl_pkg::SRC_INVALID)
        sel = retimer_ctl_pkg::SRC_MUTE;
      if (sel == retimer_ctl_pkg::SRC_QUAD && !(ovr_q[retimer_ctl_pkg::OVR_QCLK_BIT]
          && osel_q[retimer_ctl_pkg::QCLK_EN_BIT]))
        sel = retimer_ctl_pkg::SRC_MUTE;
      ctrl_d = '0;
      ctrl_d.channel_enable = detected;
      if (!detected)
        ctrl_d.out_select = retimer_ctl_pkg::SRC_MUTE;
      else if (ovr_q[retimer_ctl_pkg::OVR_MUX_BIT])
        ctrl_d.out_select = sel;
      else if (status[c].cdr_locked)
        ctrl_d.out_select = retimer_ctl_pkg::SRC_RETIMED;
      else
        ctrl_d.out_select = sel;
      ctrl_d.limiting       = stage_q[retimer_ctl_pkg::LIMIT_BIT];
      ctrl_d.boost          = boost_d;
      ctrl_d.tune_override  = tune_act;
      ctrl_d.tune_code      = tune_code;
      ctrl_d.divide_by_8    = tune_div8;
      ctrl_d.search_request = (search_q[retimer_ctl_pkg::SEARCH_HI:retimer_ctl_pkg::SEARCH_LO]
                               == retimer_ctl_pkg::SEARCH_INITIAL) && !tune_act;
      ctrl_d.rate           = rate_q[retimer_ctl_pkg::RATE_HI:retimer_ctl_pkg::RATE_LO];
      ctrl_d.subrate        = rate_q[retimer_ctl_pkg::SUBRATE_HI:retimer_ctl_pkg::SUBRATE_LO];
      ctrl_d.sync_to_input  = detected && status[c].cdr_locked;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        ctrl_q[c] <= '{default: '0, out_select: retimer_ctl_pkg::SRC_MUTE};
      else
        ctrl_q[c] <= ctrl_d;
    end

    always_comb
    begin
      case (rd_addr)
        retimer_ctl_pkg::OFS_BOOST_APPLIED:   rd_word[c] = boost_q;
        retimer_ctl_pkg::OFS_TUNE_CODE_ONE:   rd_word[c] = code1_q;
        retimer_ctl_pkg::OFS_OVERRIDE_EN:     rd_word[c] = ovr_q;
        retimer_ctl_pkg::OFS_TUNE_CODE_TWO:   rd_word[c] = code2_q;
        retimer_ctl_pkg::OFS_STAGE_CONTROL:   rd_word[c] = stage_q;
        retimer_ctl_pkg::OFS_SIG_DETECT_CTL:  rd_word[c] = sd_q;
        retimer_ctl_pkg::OFS_OUTPUT_SELECT:   rd_word[c] = osel_q;
        retimer_ctl_pkg::OFS_RATE_SUBRATE:    rd_word[c] = rate_q;
        retimer_ctl_pkg::OFS_ADAPT_MODE:      rd_word[c] = adapt_q;
        retimer_ctl_pkg::OFS_SEARCH_CONTROL:  rd_word[c] = search_q;
        retimer_ctl_pkg::OFS_LOW_RATE_BOOST:  rd_word[c] = lowb_q;
        default:                              rd_word[c] = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    rd_data_d = rd_en ? rd_word[rd_chan] : rd_data_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_en;
    end
  end

  // checks on channel 0; the others share the same generate body
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_fallback_boost;
    status[0].rate_fallback |=> g_chan[0].boost_q == $past(g_chan[0].lowb_q);
  endproperty
  a_fallback_boost: assert property (p_fallback_boost) else $error("fallback boost not loaded");

  property p_fixed_no_adapt;
    (g_chan[0].fixed_mode && !status[0].rate_fallback && !(wr_en && wr_chan == 2'h0
      && wr_addr == retimer_ctl_pkg::OFS_BOOST_APPLIED)) |=> $stable(g_chan[0].boost_q);
  endproperty
  a_fixed_no_adapt: assert property (p_fixed_no_adapt) else $error("boost moved in fixed mode");

  property p_adapt_visible;
    (status[0].adapt_update && !g_chan[0].fixed_mode && !status[0].rate_fallback)
      |=> g_chan[0].boost_q == $past(status[0].adapt_boost);
  endproperty
  a_adapt_visible: assert property (p_adapt_visible) else $error("adapted boost not held");

  property p_limiting;
    ##1 ctrl_q[0].limiting == $past(g_chan[0].stage_q[retimer_ctl_pkg::LIMIT_BIT]);
  endproperty
  a_limiting: assert property (p_limiting) else $error("limiting does not follow stage bit");

  property p_no_signal_mute;
    (!g_chan[0].sd_q[7] && !g_chan[0].sd_q[6] && !status[0].sig_present)
      |=> ctrl_q[0].out_select == retimer_ctl_pkg::SRC_MUTE && !ctrl_q[0].channel_enable;
  endproperty
  a_no_signal_mute: assert property (p_no_signal_mute) else $error("undetected channel not muted");

  property p_force_detect;
    (g_chan[0].sd_q[7] && !g_chan[0].sd_q[6]) |=> ctrl_q[0].channel_enable;
  endproperty
  a_force_detect: assert property (p_force_detect) else $error("forced detect not enabled");

  property p_locked_retimed;
    (!g_chan[0].ovr_q[5] && status[0].cdr_locked && ctrl_q[0].channel_enable)
      ##1 ctrl_q[0].channel_enable |-> ctrl_q[0].out_select == retimer_ctl_pkg::SRC_RETIMED;
  endproperty
  a_locked_retimed: assert property (p_locked_retimed) else $error("locked output not retimed");

  property p_override_sel;
    (g_chan[0].ovr_q[5] && g_chan[0].sd_q[7] && !g_chan[0].sd_q[6]
      && g_chan[0].osel_q[7:5] == retimer_ctl_pkg::SRC_INTCLK)
      |=> ctrl_q[0].out_select == retimer_ctl_pkg::SRC_INTCLK;
  endproperty
  a_override_sel: assert property (p_override_sel) else $error("override selector ignored");

  // the alternator and the output stage each add a cycle after the enable drops
  property p_tune_gate;
    !g_chan[0].ovr_q[7] [*2] |=> !ctrl_q[0].tune_override [*2];
  endproperty
  a_tune_gate: assert property (p_tune_gate) else $error("tuning override without enable");

  property p_search;
    (g_chan[0].search_q[5:4] == 2'h3 && !g_chan[0].ovr_q[7]) |-> ##[1:2] ctrl_q[0].search_request;
  endproperty
  a_search: assert property (p_search) else $error("initial search not requested");

  c_fallback: cover property (status[0].rate_fallback ##1 g_chan[0].fixed_mode);
  c_alternate: cover property (ctrl_q[0].divide_by_8 ##[1:20] !ctrl_q[0].divide_by_8
                               && ctrl_q[0].tune_override);
  c_forced_pattern: cover property (ctrl_q[0].channel_enable && !status[0].sig_present
                                    && ctrl_q[0].out_select == retimer_ctl_pkg::SRC_PATTERN);
endmodule

// *** bench/status_model.sv ***
// far-side status source for four channels: detect, lock and event pulses
// assumes bench requests are set just after a rising edge of ref_clk
`timescale 1ns/1ps
module status_model (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic [3:0]               sig_i,
  input  wire logic [3:0]               lock_i,
  input  wire logic [3:0]               adapt_i,
  input  wire logic [3:0]               fall_i,
  input  wire logic [3:0]               fail_i,
  input  wire logic [7:0]               boost_i,
  output retimer_ctl_pkg::chan_status_s status [4]
);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 4; c++)
        status[c] <= '0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        status[c].sig_present   <= sig_i[c];
        status[c].cdr_locked    <= lock_i[c];
        status[c].adapt_update  <= adapt_i[c];
        // boost bus means nothing without its strobe, so it keeps moving
        status[c].adapt_boost   <= adapt_i[c] ? boost_i : ~status[c].adapt_boost;
        status[c].rate_fallback <= fall_i[c];
        // a locked loop makes no failed attempts
        status[c].lock_attempt_fail <= fail_i[c] & ~lock_i[c];
      end
    end
  end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the per-channel override control
// assumes the decoded register port and the status model as far side
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  logic                          ref_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          wr_en = 1'b0;
  logic                          rd_en = 1'b0;
  logic [1:0]                    wr_chan = 2'h0;
  logic [1:0]                    rd_chan = 2'h0;
  logic [7:0]                    wr_addr = 8'h00;
  logic [7:0]                    wr_data = 8'h00;
  logic [7:0]                    rd_addr = 8'h00;
  logic [3:0]                    sig_i = 4'h0;
  logic [3:0]                    lock_i = 4'h0;
  logic [3:0]                    adapt_i = 4'h0;
  logic [3:0]                    fall_i = 4'h0;
  logic [3:0]                    fail_i = 4'h0;
  logic [7:0]                    boost_i = 8'h00;
  logic [7:0]                    rd_data_q;
  logic                          rd_valid_q;
  retimer_ctl_pkg::chan_status_s status [4];
  retimer_ctl_pkg::chan_ctrl_s   ctrl_q [4];
  int                            num_errors = 0;
  int                            comparisons = 0;
  int                            cycles = 0;
  logic [7:0]                    offs [11] = '{8'h03, 8'h08, 8'h09, 8'h0B, 8'h13, 8'h14,
                                               8'h1E, 8'h2F, 8'h31, 8'h36, 8'h3A};
  logic [2:0]                    exp_sel;

  status_model status_model_inst (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sig_i   (sig_i),
    .lock_i  (lock_i),
    .adapt_i (adapt_i),
    .fall_i  (fall_i),
    .fail_i  (fail_i),
    .boost_i (boost_i),
    .status  (status)
  );

  retimer_override_ctl #(.NUM_CH(4)) retimer_override_ctl_inst (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wr_en      (wr_en),
    .wr_chan    (wr_chan),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .rd_en      (rd_en),
    .rd_chan    (rd_chan),
    .rd_addr    (rd_addr),
    .status     (status),
    .rd_data_q  (rd_data_q),
    .rd_valid_q (rd_valid_q),
    .ctrl_q     (ctrl_q)
  );

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // status takes one edge in the model, then register and output stages
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    wr_en = 1'b1;
    wr_chan = ch;
    wr_addr = a;
    wr_data = d;
    @(posedge ref_clk);
    #1;
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1;
    rd_en = 1'b1;
    rd_chan = ch;
    rd_addr = a;
    @(posedge ref_clk);
    #1;
    rd_en = 1'b0;
    `CHK("read valid", 1'b1, rd_valid_q)
    `CHK("read data", e, rd_data_q)
  endtask

  // kind 0 adapt update, 1 rate fallback, 2 failed attempt
  task automatic pulse(input int kind, input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    boost_i = b;
    adapt_i[0] = (kind == 0);
    fall_i[0] = (kind == 1);
    fail_i[0] = (kind == 2);
    @(posedge ref_clk);
    #1;
    adapt_i[0] = 1'b0;
    fall_i[0] = 1'b0;
    fail_i[0] = 1'b0;
    settle();
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 11; i++)
      rd(2'h0, offs[i], (i == 6) ? 8'hE0 : 8'h00);
    rd(2'h0, 8'h40, 8'h00);
    `CHK("mute at reset", 3'h7, ctrl_q[0].out_select)
    `CHK("disabled at reset", 1'b0, ctrl_q[0].channel_enable)
    wr(2'h1, 8'h3A, 8'h5C);
    wr(2'h0, 8'h40, 8'h77);
    rd(2'h1, 8'h3A, 8'h5C);
    rd(2'h0, 8'h3A, 8'h00);
    rd(2'h0, 8'h40, 8'h00);
    // fixed boost sequence: adapt off, low-rate, applied, limiting
    wr(2'h0, 8'h31, 8'h00);
    wr(2'h0, 8'h3A, 8'h33);
    wr(2'h0, 8'h03, 8'h21);
    wr(2'h0, 8'h13, 8'h04);
    settle();
    `CHK("boost", 8'h21, ctrl_q[0].boost)
    `CHK("limiting", 1'b1, ctrl_q[0].limiting)
    `CHK("other channel", 1'b0, ctrl_q[1].limiting)
    pulse(0, 8'h5A);
    rd(2'h0, 8'h03, 8'h21);
    pulse(1, 8'h00);
    rd(2'h0, 8'h03, 8'h33);
    `CHK("fallback boost", 8'h33, ctrl_q[0].boost)
    wr(2'h0, 8'h31, 8'h20);
    pulse(0, 8'h5A);
    rd(2'h0, 8'h03, 8'h5A);
    `CHK("adapted boost", 8'h5A, ctrl_q[0].boost)
    wr(2'h0, 8'h08, 8'h0C);
    wr(2'h0, 8'h0B, 8'h15);
    settle();
    `CHK("no tune override", 1'b0, ctrl_q[0].tune_override)
    wr(2'h0, 8'h09, 8'h80);
    settle();
    `CHK("tune override", 1'b1, ctrl_q[0].tune_override)
    for (int n = 0; n < 3; n++)
    begin
      `CHK("tune code", (n % 2) ? 5'h15 : 5'h0C, ctrl_q[0].tune_code)
      `CHK("div8", (n % 2) ? 1'b0 : 1'b1, ctrl_q[0].divide_by_8)
      pulse(2, 8'h00);
    end
    wr(2'h0, 8'h09, 8'h00);
    wr(2'h0, 8'h36, 8'h30);
    wr(2'h0, 8'h2F, 8'h90);
    settle();
    `CHK("override off", 1'b0, ctrl_q[0].tune_override)
    `CHK("search", 1'b1, ctrl_q[0].search_request)
    `CHK("rate", 2'h2, ctrl_q[0].rate)
    `CHK("subrate", 2'h1, ctrl_q[0].subrate)
    wr(2'h0, 8'h14, 8'h80);
    settle();
    `CHK("forced detect", 1'b1, ctrl_q[0].channel_enable)
    `CHK("unlocked mute", 3'h7, ctrl_q[0].out_select)
    wr(2'h0, 8'h14, 8'h00);
    wr(2'h0, 8'h1E, 8'h00);
    sig_i[0] = 1'b1;
    settle();
    `CHK("auto detect", 1'b1, ctrl_q[0].channel_enable)
    `CHK("unlocked raw", 3'h0, ctrl_q[0].out_select)
    lock_i[0] = 1'b1;
    settle();
    `CHK("locked retimed", 3'h1, ctrl_q[0].out_select)
    `CHK("sync", 1'b1, ctrl_q[0].sync_to_input)
    wr(2'h0, 8'h09, 8'h20);
    for (int k = 0; k < 8; k++)
    begin
      // pattern source is picked on the selector code alone; the bench also sets bit 4 with it
      wr(2'h0, 8'h1E, {k[2:0], (k == 4) ? 5'h10 : 5'h00});
      settle();
      exp_sel = (k == 6 || k == 3) ? 3'h7 : k[2:0];
      `CHK("mux override", exp_sel, ctrl_q[0].out_select)
    end
    wr(2'h0, 8'h09, 8'h30);
    wr(2'h0, 8'h1E, 8'h61);
    settle();
    `CHK("quadrature", 3'h3, ctrl_q[0].out_select)
    `CHK("other mute", 3'h7, ctrl_q[1].out_select)
    sig_i[0] = 1'b0;
    settle();
    `CHK("lost signal", 1'b0, ctrl_q[0].channel_enable)
    `CHK("lost mute", 3'h7, ctrl_q[0].out_select)
    `CHK("free run", 1'b0, ctrl_q[0].sync_to_input)
    wr(2'h0, 8'h14, 8'h80);
    wr(2'h0, 8'h1E, 8'h90);
    settle();
    `CHK("forced pattern", 3'h4, ctrl_q[0].out_select)
    `CHK("forced enable", 1'b1, ctrl_q[0].channel_enable)
    conclude();
  end
endmodule
